// File: pkg/modem_regs_pkg.sv
package modem_regs_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IDX_MODEM_TEST_CONTROL = 16'hDF05;
    localparam logic [15:0] IDX_CLEAR_CHANNEL_THRESHOLD = 16'hDF06;
    localparam logic [15:0] IDX_SIGNAL_STRENGTH_VALUE = 16'hDF07;
    localparam logic [15:0] IDX_SYNC_PATTERN_HIGH = 16'hDF08;
    localparam logic [15:0] IDX_SYNC_PATTERN_LOW = 16'hDF09;
    localparam logic [15:0] IDX_TRANSMIT_CONTROL_HIGH = 16'hDF0A;
    localparam logic [15:0] IDX_TRANSMIT_CONTROL_LOW = 16'hDF0B;
    localparam logic [15:0] IDX_CLEAR_CHANNEL_CONFIG = 16'hDF3E;
    localparam logic [15:0] IDX_MODEM_STATUS = 16'hDF3F;

    // Modem test control fields.
    localparam int DC_AVG_BIT = 5;
    localparam int MOD_POL_BIT = 4;
    localparam int TX_TEST_LSB = 2;
    localparam int RX_TEST_LSB = 0;
    localparam logic [5:0] TEST_CONTROL_WMASK = 6'h3F;

    // Transmit control high fields.
    localparam int MIXBUF_LSB = 6;
    localparam int WAIT_SEL_BIT = 5;
    localparam int VARACTOR_LSB = 3;
    localparam int MIXCUR_LSB = 1;
    localparam int AMP_SEL_BIT = 0;

    // Transmit control low fields.
    localparam int AMP_CUR_LSB = 5;
    localparam int AMP_LEVEL_LSB = 0;

    // Clear-channel configuration fields.
    localparam int CC_MODE_LSB = 3;
    localparam int CC_HYST_LSB = 0;

    // Reset values.
    localparam logic [7:0] RST_MODEM_TEST_CONTROL = 8'h00;
    localparam logic [7:0] RST_CLEAR_CHANNEL_THRESHOLD = 8'hE0;
    localparam logic [7:0] RST_SIGNAL_STRENGTH_VALUE = 8'h80;
    localparam logic [7:0] RST_SYNC_PATTERN_HIGH = 8'hA7;
    localparam logic [7:0] RST_SYNC_PATTERN_LOW = 8'h0F;
    localparam logic [7:0] RST_TRANSMIT_CONTROL_HIGH = 8'hA1;
    localparam logic [7:0] RST_TRANSMIT_CONTROL_LOW = 8'h7F;
    localparam logic [7:0] RST_CLEAR_CHANNEL_CONFIG = 8'h1A;

    // Codes.
    localparam logic [1:0] TX_SRC_QUEUE = 2'h0;
    localparam logic [1:0] TX_SRC_SERIAL = 2'h1;
    localparam logic [1:0] TX_SRC_LOOP = 2'h2;
    localparam logic [1:0] TX_SRC_RANDOM = 2'h3;
    localparam logic [1:0] RX_SNK_QUEUE = 2'h0;
    localparam logic [1:0] RX_SNK_SERIAL = 2'h1;
    localparam logic [1:0] RX_SNK_LOOP = 2'h2;
    localparam logic [1:0] CC_MODE_HYST = 2'h1;
    localparam logic [3:0] NIBBLE_ONES = 4'hF;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;

    // Timing.
    localparam int CLK_PERIOD_NS = 40;
    localparam int TURNAROUND_SHORT_US = 128;
    localparam int TURNAROUND_LONG_US = 192;
    localparam int TURNAROUND_SHORT_CYC =
        TURNAROUND_SHORT_US * 1000 / CLK_PERIOD_NS;
    localparam int TURNAROUND_LONG_CYC =
        TURNAROUND_LONG_US * 1000 / CLK_PERIOD_NS;
    localparam int AVG_SYMBOLS = 8;
    localparam int AVG_SHIFT = 3;

endpackage

// File: hdl/radio_modem_control_regs.sv
`timescale 1ns/1ps

module radio_modem_control_regs #(
    parameter int ADDR_W = 18,
    parameter int SHORT_WAIT_CYC = modem_regs_pkg::TURNAROUND_SHORT_CYC,
    parameter int LONG_WAIT_CYC = modem_regs_pkg::TURNAROUND_LONG_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    // Wishbone classic slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Datapath side.
    input wire logic preamble_matched,
    input wire logic symbol_valid,
    input wire logic [7:0] received_signal_strength,
    input wire logic [3:0] rx_symbol,
    input wire logic [1:0] tx_sync_index,
    input wire logic transmit_on_strobe,
    output logic dc_level_freeze,
    output logic phase_reversed,
    output logic [1:0] tx_source,
    output logic tx_from_queue,
    output logic tx_serial_in,
    output logic tx_queue_loop,
    output logic tx_random,
    output logic rx_to_queue,
    output logic rx_serial_out,
    output logic rx_queue_loop,
    output logic clear_channel_signal,
    output logic [7:0] signal_strength_estimate,
    output logic [3:0] tx_sync_nibble,
    output logic sync_found,
    output logic transmit_waiting,
    output logic transmit_start,
    output logic amp_output_select,
    output logic [2:0] amp_current_code,
    output logic [4:0] amp_output_level,
    output logic [1:0] tx_mixer_buffer_bias,
    output logic [1:0] tx_mixer_current_code,
    output logic [1:0] tx_mixer_varactor
);

    typedef enum logic [1:0] {
        TA_IDLE = 2'b00,
        TA_WAIT = 2'b01,
        TA_FIRE = 2'b11
    } turnaround_t;

    logic [5:0] test_control_r;
    logic [7:0] threshold_r;
    logic [7:0] strength_r;
    logic [7:0] sync_high_r;
    logic [7:0] sync_low_r;
    logic [7:0] tx_high_r;
    logic [7:0] tx_low_r;
    logic [4:0] cc_config_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [15:0] index;
    logic index_ok;
    logic wr_en;
    logic [7:0] rd_nxt;
    logic [15:0] sync_pattern;
    logic [10:0] sum_r;
    logic [2:0] sample_cnt_r;
    logic [3:0] hist_r [0:4];
    logic sync_found_r;
    logic [3:0] tx_nibble_r;
    logic cc_r;
    turnaround_t ta_state_r;
    logic [12:0] wait_cnt_r;
    logic [12:0] wait_len;
    logic sync_match;
    logic sym_seen_r;

    // Pick nibble n of the sync pattern, least significant first.
    function automatic logic [3:0] nibble_of(input logic [15:0] pat,
                                             input logic [1:0] n);
        nibble_of = pat[{n, 2'b00} +: 4];
    endfunction

    // Sign-extend an 8-bit dB value for arithmetic without overflow.
    function automatic logic signed [9:0] sx(input logic [7:0] v);
        sx = signed'({{2{v[7]}}, v});
    endfunction

    // Byte index decode: the lowest two address bits select nothing.
    always_comb begin
        index = 16'h0000;
        index[ADDR_W-3:0] = adr_i[ADDR_W-1:2];
        index_ok = 1'b1;
        if (index == modem_regs_pkg::IDX_MODEM_TEST_CONTROL) begin
            rd_nxt = {2'b00, test_control_r};
        end else if (index ==
                modem_regs_pkg::IDX_CLEAR_CHANNEL_THRESHOLD) begin
            rd_nxt = threshold_r;
        end else if (index == modem_regs_pkg::IDX_SIGNAL_STRENGTH_VALUE) begin
            rd_nxt = strength_r;
        end else if (index == modem_regs_pkg::IDX_SYNC_PATTERN_HIGH) begin
            rd_nxt = sync_high_r;
        end else if (index == modem_regs_pkg::IDX_SYNC_PATTERN_LOW) begin
            rd_nxt = sync_low_r;
        end else if (index == modem_regs_pkg::IDX_TRANSMIT_CONTROL_HIGH) begin
            rd_nxt = tx_high_r;
        end else if (index == modem_regs_pkg::IDX_TRANSMIT_CONTROL_LOW) begin
            rd_nxt = tx_low_r;
        end else if (index == modem_regs_pkg::IDX_CLEAR_CHANNEL_CONFIG) begin
            rd_nxt = {3'b000, cc_config_r};
        end else if (index == modem_regs_pkg::IDX_MODEM_STATUS) begin
            rd_nxt = {5'b00000, transmit_waiting, sync_found_r, cc_r};
        end else begin
            rd_nxt = 8'h00;
            index_ok = 1'b0;
        end
    end

    // A write lands on the edge at which the master sees the acknowledge.
    assign wr_en = cyc_i & stb_i & we_i & ack_r & sel_i[0] & index_ok;

    // One wait state: acknowledge the cycle after the strobe, then drop it.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            ack_r <= cyc_i & stb_i & ~ack_r;
            rdata_r <= {24'h000000, rd_nxt};
        end
    end

    assign ack_o = ack_r;
    assign dat_o = rdata_r;

    // Configuration storage.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            test_control_r <= modem_regs_pkg::RST_MODEM_TEST_CONTROL[5:0];
            threshold_r <= modem_regs_pkg::RST_CLEAR_CHANNEL_THRESHOLD;
            sync_high_r <= modem_regs_pkg::RST_SYNC_PATTERN_HIGH;
            sync_low_r <= modem_regs_pkg::RST_SYNC_PATTERN_LOW;
            tx_high_r <= modem_regs_pkg::RST_TRANSMIT_CONTROL_HIGH;
            tx_low_r <= modem_regs_pkg::RST_TRANSMIT_CONTROL_LOW;
            cc_config_r <= modem_regs_pkg::RST_CLEAR_CHANNEL_CONFIG[4:0];
        end else if (wr_en) begin
            if (index == modem_regs_pkg::IDX_MODEM_TEST_CONTROL) begin
                test_control_r <= dat_i[5:0] &
                    modem_regs_pkg::TEST_CONTROL_WMASK;
            end else if (index ==
                    modem_regs_pkg::IDX_CLEAR_CHANNEL_THRESHOLD) begin
                threshold_r <= dat_i[7:0];
            end else if (index == modem_regs_pkg::IDX_SYNC_PATTERN_HIGH) begin
                sync_high_r <= dat_i[7:0];
            end else if (index == modem_regs_pkg::IDX_SYNC_PATTERN_LOW) begin
                sync_low_r <= dat_i[7:0];
            end else if (index ==
                    modem_regs_pkg::IDX_TRANSMIT_CONTROL_HIGH) begin
                tx_high_r <= dat_i[7:0];
            end else if (index ==
                    modem_regs_pkg::IDX_TRANSMIT_CONTROL_LOW) begin
                tx_low_r <= dat_i[7:0];
            end else if (index ==
                    modem_regs_pkg::IDX_CLEAR_CHANNEL_CONFIG) begin
                cc_config_r <= dat_i[4:0];
            end
        end
    end

    // Mode decode toward the datapath.
    always_comb begin
        tx_source = test_control_r[modem_regs_pkg::TX_TEST_LSB +: 2];
        tx_from_queue = tx_source == modem_regs_pkg::TX_SRC_QUEUE;
        tx_serial_in = tx_source == modem_regs_pkg::TX_SRC_SERIAL;
        tx_queue_loop = tx_source == modem_regs_pkg::TX_SRC_LOOP;
        tx_random = tx_source == modem_regs_pkg::TX_SRC_RANDOM;
        // The reserved receive code enables no sink at all.
        rx_to_queue = test_control_r[modem_regs_pkg::RX_TEST_LSB +: 2] ==
            modem_regs_pkg::RX_SNK_QUEUE;
        rx_serial_out = test_control_r[modem_regs_pkg::RX_TEST_LSB +: 2] ==
            modem_regs_pkg::RX_SNK_SERIAL;
        rx_queue_loop = test_control_r[modem_regs_pkg::RX_TEST_LSB +: 2] ==
            modem_regs_pkg::RX_SNK_LOOP;
        dc_level_freeze = preamble_matched &
            ~test_control_r[modem_regs_pkg::DC_AVG_BIT];
        phase_reversed = test_control_r[modem_regs_pkg::MOD_POL_BIT];
    end

    // Analog settings are straight register fields.
    assign amp_output_select = tx_high_r[modem_regs_pkg::AMP_SEL_BIT];
    assign amp_current_code =
        tx_low_r[modem_regs_pkg::AMP_CUR_LSB +: 3];
    assign amp_output_level =
        tx_low_r[modem_regs_pkg::AMP_LEVEL_LSB +: 5];
    assign tx_mixer_buffer_bias =
        tx_high_r[modem_regs_pkg::MIXBUF_LSB +: 2];
    assign tx_mixer_current_code =
        tx_high_r[modem_regs_pkg::MIXCUR_LSB +: 2];
    assign tx_mixer_varactor =
        tx_high_r[modem_regs_pkg::VARACTOR_LSB +: 2];

    // Block average over eight symbols; the estimate updates once per block.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sum_r <= 11'h000;
            sample_cnt_r <= 3'h0;
            strength_r <= modem_regs_pkg::RST_SIGNAL_STRENGTH_VALUE;
        end else if (symbol_valid) begin
            sample_cnt_r <= sample_cnt_r + 3'h1;
            if (sample_cnt_r == 3'(modem_regs_pkg::AVG_SYMBOLS - 1)) begin
                sum_r <= 11'h000;
                // Bits 10:3 of the wrapped sum are the floor of the mean.
                strength_r <= 8'((sum_r + 11'(sx(received_signal_strength)))
                    >> modem_regs_pkg::AVG_SHIFT);
            end else begin
                sum_r <= sum_r + 11'(sx(received_signal_strength));
            end
        end
    end

    assign signal_strength_estimate = strength_r;

    // Clear-channel decision on the averaged estimate.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cc_r <= 1'b0;
        end else if (cc_config_r[modem_regs_pkg::CC_MODE_LSB +: 2] ==
                modem_regs_pkg::CC_MODE_HYST) begin
            cc_r <= sx(strength_r) < sx(threshold_r) - signed'(
                10'(cc_config_r[modem_regs_pkg::CC_HYST_LSB +: 3]));
        end else begin
            cc_r <= sx(strength_r) < sx(threshold_r);
        end
    end

    assign clear_channel_signal = cc_r;
    assign sync_pattern = {sync_high_r, sync_low_r};

    // Modulator side: nibble index 0 is the first one sent.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_nibble_r <= modem_regs_pkg::NIBBLE_ZERO;
        end else if (nibble_of(sync_pattern, tx_sync_index) ==
                modem_regs_pkg::NIBBLE_ONES) begin
            tx_nibble_r <= modem_regs_pkg::NIBBLE_ZERO;
        end else begin
            tx_nibble_r <= nibble_of(sync_pattern, tx_sync_index);
        end
    end

    assign tx_sync_nibble = tx_nibble_r;

    // Symbol history: hist_r[0] is the newest symbol received.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 5; i++) begin
                hist_r[i] <= modem_regs_pkg::NIBBLE_ONES;
            end
        end else if (symbol_valid) begin
            hist_r[0] <= rx_symbol;
            for (int i = 1; i < 5; i++) begin
                hist_r[i] <= hist_r[i-1];
            end
        end
    end

    // Nibble n of the pattern arrived as hist_r[3-n]. The symbol just before
    // the first required nibble must be zero; an all-ones pattern thus asks
    // only for the newest symbol to be zero.
    always_comb begin
        logic seen;
        seen = 1'b0;
        sync_match = 1'b1;
        for (int n = 0; n < 4; n++) begin
            if (nibble_of(sync_pattern, 2'(n)) !=
                    modem_regs_pkg::NIBBLE_ONES) begin
                if (hist_r[3-n] != nibble_of(sync_pattern, 2'(n))) begin
                    sync_match = 1'b0;
                end
                if (!seen && hist_r[4-n] != modem_regs_pkg::NIBBLE_ZERO) begin
                    sync_match = 1'b0;
                end
                seen = 1'b1;
            end
        end
        if (!seen && hist_r[0] != modem_regs_pkg::NIBBLE_ZERO) begin
            sync_match = 1'b0;
        end
    end

    // The history shifts on the symbol edge, so the match waits a cycle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sym_seen_r <= 1'b0;
        end else begin
            sym_seen_r <= symbol_valid;
        end
    end

    // Checked once per new symbol, so the pulse lasts a single cycle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_found_r <= 1'b0;
        end else begin
            sync_found_r <= sym_seen_r & sync_match;
        end
    end

    assign sync_found = sync_found_r;

    // Turnaround wait. The length is latched at the strobe, so a rewrite of
    // the select during the wait does not stretch or cut it.
    assign wait_len = tx_high_r[modem_regs_pkg::WAIT_SEL_BIT] ?
        13'(LONG_WAIT_CYC - 1) : 13'(SHORT_WAIT_CYC - 1);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ta_state_r <= TA_IDLE;
            wait_cnt_r <= 13'h0000;
        end else begin
            case (ta_state_r)
                TA_IDLE: begin
                    if (transmit_on_strobe) begin
                        ta_state_r <= TA_WAIT;
                        wait_cnt_r <= wait_len;
                    end
                end
                TA_WAIT: begin
                    if (wait_cnt_r == 13'h0000) begin
                        ta_state_r <= TA_FIRE;
                    end else begin
                        wait_cnt_r <= wait_cnt_r - 13'h0001;
                    end
                end
                TA_FIRE: begin
                    ta_state_r <= TA_IDLE;
                end
                default: begin
                    ta_state_r <= TA_IDLE;
                end
            endcase
        end
    end

    assign transmit_waiting = ta_state_r == TA_WAIT;
    assign transmit_start = ta_state_r == TA_FIRE;

endmodule

// File: test/modem_regs_checker.sv
`timescale 1ns/1ps

module modem_regs_checker #(
    parameter int SHORT_WAIT_CYC = 8,
    parameter int LONG_WAIT_CYC = 12
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic preamble_matched,
    input wire logic symbol_valid,
    input wire logic transmit_on_strobe,
    input wire logic dc_level_freeze,
    input wire logic [1:0] tx_source,
    input wire logic tx_from_queue,
    input wire logic tx_serial_in,
    input wire logic tx_queue_loop,
    input wire logic tx_random,
    input wire logic rx_to_queue,
    input wire logic rx_serial_out,
    input wire logic rx_queue_loop,
    input wire logic [7:0] signal_strength_estimate,
    input wire logic [3:0] tx_sync_nibble,
    input wire logic sync_found,
    input wire logic transmit_waiting,
    input wire logic transmit_start
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Length of the current wait; a restarted wait would overshoot it.
    int wait_cnt_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_cnt_r <= 0;
        end else begin
            wait_cnt_r <= transmit_waiting ? wait_cnt_r + 1 : 0;
        end
    end

    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("read data has upper bits set");
    a_dc_freeze: assert property (!preamble_matched |-> !dc_level_freeze)
        else $error("dc level frozen without preamble match");
    a_tx_decode: assert property ({tx_random, tx_queue_loop, tx_serial_in,
        tx_from_queue} == (4'h1 << tx_source))
        else $error("transmit source decode wrong");
    a_rx_decode: assert property ($onehot0({rx_queue_loop, rx_serial_out,
        rx_to_queue}))
        else $error("receive sink decode not one-hot");
    a_est_cause: assert property ($changed(signal_strength_estimate) |->
        $past(symbol_valid) || $past(symbol_valid, 2))
        else $error("estimate changed without a symbol");
    a_sync_cause: assert property (sync_found |->
        $past(symbol_valid) || $past(symbol_valid, 2))
        else $error("sync found without a symbol");
    a_nibble_ones: assert property (tx_sync_nibble != 4'hF)
        else $error("all-ones sync nibble transmitted");
    a_wait_len: assert property (transmit_start |->
        wait_cnt_r == SHORT_WAIT_CYC || wait_cnt_r == LONG_WAIT_CYC)
        else $error("turnaround wait has wrong length");
    a_strobe_wait: assert property (transmit_on_strobe && !transmit_waiting
        && !transmit_start |=> transmit_waiting)
        else $error("strobe did not start the wait");
    a_start_pulse: assert property (transmit_start |=>
        !transmit_start && !transmit_waiting)
        else $error("transmit start not a single pulse");

    c_ack: cover property (ack_o);
    c_sync: cover property (sync_found);
    c_start: cover property (transmit_start);
endmodule

bind radio_modem_control_regs modem_regs_checker #(
    .SHORT_WAIT_CYC(SHORT_WAIT_CYC),
    .LONG_WAIT_CYC(LONG_WAIT_CYC)
) checker_inst (.ref_clk, .rst, .cyc_i, .stb_i, .dat_o, .ack_o,
    .preamble_matched, .symbol_valid, .transmit_on_strobe, .dc_level_freeze,
    .tx_source, .tx_from_queue, .tx_serial_in, .tx_queue_loop, .tx_random,
    .rx_to_queue, .rx_serial_out, .rx_queue_loop, .signal_strength_estimate,
    .tx_sync_nibble, .sync_found, .transmit_waiting, .transmit_start);

// File: test/front_end_model.sv
`timescale 1ns/1ps

module front_end_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [3:0] sym,
    input wire logic [7:0] rss_in,
    output logic symbol_valid,
    output logic [3:0] rx_symbol,
    output logic [7:0] received_signal_strength
);
    // Outside a valid cycle the data toggles, so a stale sample shows up.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            symbol_valid <= 1'h0;
            rx_symbol <= 4'h0;
            received_signal_strength <= 8'h00;
        end else if (go && !symbol_valid) begin
            symbol_valid <= 1'h1;
            rx_symbol <= sym;
            received_signal_strength <= rss_in;
        end else begin
            symbol_valid <= 1'h0;
            rx_symbol <= ~rx_symbol;
            received_signal_strength <= ~received_signal_strength;
        end
    end
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module testbench;
    localparam int SW = 8;
    localparam int LW = 12;
    localparam logic [15:0] BASE = modem_regs_pkg::IDX_MODEM_TEST_CONTROL;
    int miscompares = 0;
    int comparisons = 0;
    int syncs = 0;
    logic ref_clk = 1'h0, rst = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
    logic we_i = 1'h0, preamble_matched = 1'h0, transmit_on_strobe = 1'h0;
    logic fe_go = 1'h0;
    logic [3:0] fe_sym = 4'h0;
    logic [7:0] fe_rss = 8'h00;
    logic [1:0] tx_sync_index = 2'h0;
    logic [17:0] adr_i = 18'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [3:0] rx_symbol, tx_sync_nibble;
    logic [7:0] received_signal_strength, signal_strength_estimate;
    logic [1:0] tx_source, tx_mixer_buffer_bias, tx_mixer_current_code;
    logic [1:0] tx_mixer_varactor;
    logic [2:0] amp_current_code;
    logic [4:0] amp_output_level;
    logic ack_o, symbol_valid, dc_level_freeze, phase_reversed;
    logic tx_from_queue, tx_serial_in, tx_queue_loop, tx_random;
    logic rx_to_queue, rx_serial_out, rx_queue_loop, clear_channel_signal;
    logic sync_found, transmit_waiting, transmit_start, amp_output_select;
    logic [7:0] shadow [8] = '{8'h00, 8'hE0, 8'h80, 8'hA7, 8'h0F, 8'hA1,
        8'h7F, 8'h00};

    radio_modem_control_regs #(.SHORT_WAIT_CYC(SW), .LONG_WAIT_CYC(LW))
    radio_modem_control_regs_inst (.ref_clk, .rst, .cyc_i, .stb_i, .we_i,
        .adr_i, .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .preamble_matched,
        .symbol_valid, .received_signal_strength, .rx_symbol, .tx_sync_index,
        .transmit_on_strobe, .dc_level_freeze, .phase_reversed, .tx_source,
        .tx_from_queue, .tx_serial_in, .tx_queue_loop, .tx_random,
        .rx_to_queue, .rx_serial_out, .rx_queue_loop, .clear_channel_signal,
        .signal_strength_estimate, .tx_sync_nibble, .sync_found,
        .transmit_waiting, .transmit_start, .amp_output_select,
        .amp_current_code, .amp_output_level, .tx_mixer_buffer_bias,
        .tx_mixer_current_code, .tx_mixer_varactor);

    front_end_model front_end_model_inst (.ref_clk, .rst, .go(fe_go),
        .sym(fe_sym), .rss_in(fe_rss), .symbol_valid, .rx_symbol,
        .received_signal_strength);

    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (sync_found === 1'h1) syncs++;

    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // The test control top bits read as zero; the estimate and unmapped slots keep state.
    function automatic logic [7:0] exp_wr(int i, logic [7:0] d,
                                         logic [7:0] old);
        if (i == 0) return d & 8'h3F;
        return (i == 2 || i == 7) ? old : d;
    endfunction

    function automatic logic [3:0] exp_nib(logic [15:0] p, int i);
        logic [3:0] n;
        n = p[4 * i +: 4];
        return n == 4'hF ? 4'h0 : n;
    endfunction

    task automatic stop_test();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic give_up(input logic ok);
        if (!ok) begin
            miscompares++;
            stop_test();
        end
    endtask

    task automatic wb(input logic w, input logic [15:0] idx,
                      input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge ref_clk);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= {idx, 2'h0};
        dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack_o !== 1'h1 && n < 20);
        give_up(ack_o === 1'h1);
        q = dat_o[7:0];
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'h1, idx, d, q);
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic send_sym(input logic [3:0] s, input logic [7:0] r);
        @(posedge ref_clk);
        fe_go <= 1'h1;
        fe_sym <= s;
        fe_rss <= r;
        @(posedge ref_clk);
        fe_go <= 1'h0;
        repeat (3) @(posedge ref_clk);
    endtask

    initial begin
        logic [15:0] lf;
        logic [31:0] seq;
        logic [7:0] q, d, est;
        int i, n, sum;
        lf = 16'h444E;
        seq = 32'h507A007A;
        repeat (20) @(posedge ref_clk);
        rst <= 1'h0;
        for (i = 0; i < 8; i++) begin
            wb(1'h0, BASE + 16'(i), 8'h00, q);
            `CHK(q, shadow[i])
        end
        `CHK({amp_output_select, amp_current_code, amp_output_level}, 9'h17F)
        `CHK({tx_mixer_buffer_bias, tx_mixer_current_code, tx_mixer_varactor}, 6'h20)
        for (n = 0; n < 32; n++) begin
            lf = lfsr(lf);
            i = lf[2:0];
            d = lf[15:8];
            wb(1'h1, BASE + 16'(i), d, q);
            shadow[i] = exp_wr(i, d, shadow[i]);
            wb(1'h0, BASE + 16'(i), 8'h00, q);
            `CHK(q, shadow[i])
        end
        `CHK({tx_mixer_buffer_bias, amp_output_select}, {shadow[5][7:6], shadow[5][0]})
        `CHK({tx_mixer_varactor, tx_mixer_current_code}, shadow[5][4:1])
        `CHK({amp_current_code, amp_output_level}, shadow[6])
        `CHK({phase_reversed, tx_source}, shadow[0][4:2])
        preamble_matched <= 1'h1;
        for (i = 0; i < 4; i++) begin
            wr(BASE, {2'h0, i[0], i[1], i[1:0], i[1:0]});
            `CHK({tx_random, tx_queue_loop, tx_serial_in, tx_from_queue}, 4'h1 << i)
            `CHK({rx_queue_loop, rx_serial_out, rx_to_queue}, i == 3 ? 3'h0 : 3'h1 << i)
            `CHK({dc_level_freeze, phase_reversed}, {~i[0], i[1]})
        end
        sum = 0;
        for (i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            d = {{3{lf[4]}}, lf[4:0]};
            sum += $signed(d);
            send_sym(4'h5, d);
        end
        est = 8'(sum >>> 3);
        `CHK(signal_strength_estimate, est)
        wr(BASE + 16'h1, est + 8'h01);
        `CHK(clear_channel_signal, 1'h1)
        wr(modem_regs_pkg::IDX_CLEAR_CHANNEL_CONFIG, 8'h0A);
        `CHK(clear_channel_signal, 1'h0)
        wr(BASE + 16'h1, est + 8'h03);
        `CHK(clear_channel_signal, 1'h1)
        wr(BASE + 16'h3, 8'hF3);
        wr(BASE + 16'h4, 8'h5F);
        for (i = 0; i < 4; i++) begin
            tx_sync_index <= 2'(i);
            repeat (2) @(posedge ref_clk);
            `CHK(tx_sync_nibble, exp_nib(16'hF35F, i))
        end
        wr(BASE + 16'h3, 8'hA7);
        wr(BASE + 16'h4, 8'h0F);
        n = syncs;
        for (i = 0; i < 8; i++) begin
            send_sym(seq[31 - 4 * i -: 4], 8'h00);
            if (i == 3) `CHK(syncs, n)
        end
        @(posedge ref_clk);
        `CHK(syncs, n + 1)
        for (i = 0; i < 2; i++) begin
            wr(BASE + 16'h5, {2'h2, 1'(i), 5'h01});
            transmit_on_strobe <= 1'h1;
            @(posedge ref_clk);
            transmit_on_strobe <= 1'h0;
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
                transmit_on_strobe <= (n == 3);
            end while (transmit_start !== 1'h1 && n < 40);
            give_up(transmit_start === 1'h1);
            `CHK(n, (i ? LW : SW) + 1)
        end
        stop_test();
    end
endmodule
